// ===== rtl/bdes_defines.svh
// Operation
// [RL1] diagnostic status word mirrors debug buses 3..0, top byte to bottom byte
// [RL2] upper-limit word bits 31:16 hold register zone upper bound, reset zero
// [RL3] upper-limit word bits 15:0 hold exchange-memory zone upper bound
// [RL4] lower-limit word bits 31:16 hold register zone lower bound
// [RL5] lower-limit word bits 15:0 hold exchange-memory zone lower bound
// [RL6] error bit 17 set on second event interrupt while first unacknowledged
// [RL7] error bit 16 set when receive data buffer pointer is null
// [RL8] error bit 15 set on null transmit buffer pointer in advert or payload
// [RL9] error bit 14 set when receive descriptor pointer is null
// [RL10] error bit 13 set on null transmit descriptor in advert/scan/init events; code sets it only with adv_event
// [RL11] error bit 12 set when control-structure format code is invalid
// [RL12] error bit 11 set when channel map count differs from good count
// [RL13] zone flags hit inside inclusive bounds; writes to status words ignored
`ifndef BDES_DEFINES_SVH
`define BDES_DEFINES_SVH

// register byte addresses
`define BDES_ADDR_DBG_MIRROR 32'h4000_0054
`define BDES_ADDR_ZONE_UPPER 32'h4000_0058
`define BDES_ADDR_ZONE_LOWER 32'h4000_005c
`define BDES_ADDR_ERR_FLAGS 32'h4000_0060
`define BDES_ADDR_ERR_CLEAR 32'h4000_0064
`define BDES_ADDR_ZONE_STAT 32'h4000_0068

// reset values
`define BDES_RST_LIMITS 32'h0000_0000
`define BDES_RST_WORD 32'h0000_0000

// limit word fields
`define BDES_REGZONE_MSB 31
`define BDES_REGZONE_LSB 16
`define BDES_MEMZONE_MSB 15
`define BDES_MEMZONE_LSB 0

// error word: flags occupy bits 17 down to 11
`define BDES_ERR_MSB 17
`define BDES_ERR_LSB 11
`define BDES_ERR_N 7
`define BDES_BIT_EVT_OVERLAP 6
`define BDES_BIT_RX_BUF 5
`define BDES_BIT_TX_BUF 4
`define BDES_BIT_RX_DESC 3
`define BDES_BIT_TX_DESC 2
`define BDES_BIT_CTRL_FMT 1
`define BDES_BIT_CHAN_MAP 0

// zone status word
`define BDES_ZSTAT_REG_BIT 1
`define BDES_ZSTAT_MEM_BIT 0

// channel map and format widths
`define BDES_CHMAP_W 37
`define BDES_CHCNT_W 6
`define BDES_FMT_W 5
// one bit per legal control-structure format code
`define BDES_FMT_VALID_MASK 32'h0000_ffff

`endif

// ===== rtl/bdes_pkg.sv
`include "bdes_defines.svh"

package bdes_pkg;

   typedef logic [`BDES_ERR_N-1:0] bdes_err_t;

   typedef struct packed {
      logic [31:0] zone_upper;
      logic [31:0] zone_lower;
      logic [31:0] rdata;
      bdes_err_t clr;
   } bdes_top_s;

   typedef struct packed {
      bdes_err_t flags;
      logic irq_pending;
   } bdes_err_s;

   typedef struct packed {
      logic hit;
   } bdes_zone_s;

endpackage : bdes_pkg

// ===== rtl/bdes_err_if.sv
`include "bdes_defines.svh"

interface bdes_err_if;
   import bdes_pkg::*;

   // event interrupt bookkeeping
   logic evt_irq;
   logic evt_ack;
   // pointer checks, each strobe qualifies its value
   logic rx_buf_chk;
   logic [15:0] rx_buf_ptr;
   logic tx_buf_chk;
   logic [15:0] tx_buf_ptr;
   logic adv_event;
   logic [7:0] tx_pkt_len;
   logic rx_desc_chk;
   logic [15:0] rx_desc_ptr;
   logic tx_desc_chk;
   logic [15:0] tx_desc_ptr;
   logic fmt_chk;
   logic [`BDES_FMT_W-1:0] fmt_code;
   logic hop_start;
   logic [`BDES_CHMAP_W-1:0] chan_map;
   logic [`BDES_CHCNT_W-1:0] good_count;
   // software clear and resulting flags
   bdes_err_t clr;
   bdes_err_t flags;

   modport src (
      output evt_irq, evt_ack, rx_buf_chk, rx_buf_ptr, tx_buf_chk,
      output tx_buf_ptr, adv_event, tx_pkt_len, rx_desc_chk, rx_desc_ptr,
      output tx_desc_chk, tx_desc_ptr, fmt_chk, fmt_code, hop_start,
      output chan_map, good_count, clr,
      input flags
   );

   modport mon (
      input evt_irq, evt_ack, rx_buf_chk, rx_buf_ptr, tx_buf_chk,
      input tx_buf_ptr, adv_event, tx_pkt_len, rx_desc_chk, rx_desc_ptr,
      input tx_desc_chk, tx_desc_ptr, fmt_chk, fmt_code, hop_start,
      input chan_map, good_count, clr,
      output flags
   );

endinterface : bdes_err_if

// ===== rtl/bdes_zone_cmp.sv
module bdes_zone_cmp
   import bdes_pkg::*;
(
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst_n,
   // access under watch
   input wire logic acc_valid,
   input wire logic [15:0] acc_addr,
   // zone bounds
   input wire logic [15:0] lower,
   input wire logic [15:0] upper,
   // result
   output logic hit
);

   bdes_zone_s s;
   bdes_zone_s next_s;

   always_comb begin
      next_s = s;
      // inclusive on both ends; lower above upper gives an empty zone
      next_s.hit = acc_valid && (acc_addr >= lower) && (acc_addr <= upper); // RL13
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign hit = s.hit;

endmodule : bdes_zone_cmp

// ===== rtl/bdes_err_flags.sv
`include "bdes_defines.svh"

module bdes_err_flags
   import bdes_pkg::*;
(
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst_n,
   // checks in, flags out
   bdes_err_if.mon chk
);

   bdes_err_s s;
   bdes_err_s next_s;
   bdes_err_t set;

   function automatic logic [`BDES_CHCNT_W-1:0] count_ones(
      input logic [`BDES_CHMAP_W-1:0] map);
      logic [`BDES_CHCNT_W-1:0] n;
      n = '0;
      for (int i = 0; i < `BDES_CHMAP_W; i++) begin
         n = n + {{(`BDES_CHCNT_W-1){1'b0}}, map[i]};
      end
      return n;
   endfunction

   function automatic logic fmt_legal(input logic [`BDES_FMT_W-1:0] code);
      logic [31:0] mask;
      mask = `BDES_FMT_VALID_MASK;
      return mask[code];
   endfunction

   always_comb begin
      set = '0;
      // an ack in the same cycle as the new request frees the slot in time
      set[`BDES_BIT_EVT_OVERLAP] = chk.evt_irq && s.irq_pending &&
                                   !chk.evt_ack; // RL6
      set[`BDES_BIT_RX_BUF] = chk.rx_buf_chk && (chk.rx_buf_ptr == '0); // RL7
      set[`BDES_BIT_TX_BUF] = chk.tx_buf_chk && (chk.tx_buf_ptr == '0) &&
                              (chk.adv_event || chk.tx_pkt_len != '0); // RL8
      set[`BDES_BIT_RX_DESC] = chk.rx_desc_chk &&
                               (chk.rx_desc_ptr == '0); // RL9
      set[`BDES_BIT_TX_DESC] = chk.tx_desc_chk && chk.adv_event &&
                               (chk.tx_desc_ptr == '0); // RL10
      set[`BDES_BIT_CTRL_FMT] = chk.fmt_chk &&
                                !fmt_legal(chk.fmt_code); // RL11
      set[`BDES_BIT_CHAN_MAP] = chk.hop_start &&
         (count_ones(chk.chan_map) != chk.good_count); // RL12
      next_s = s;
      // a new error in the clearing cycle survives the clear
      next_s.flags = (s.flags & ~chk.clr) | set;
      next_s.irq_pending = chk.evt_irq || (s.irq_pending && !chk.evt_ack);
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign chk.flags = s.flags;

endmodule : bdes_err_flags

// ===== rtl/bdes_top.sv
`include "bdes_defines.svh"

module bdes_top
   import bdes_pkg::*;
(
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst_n,
   // register port
   input wire logic [31:0] addr,
   input wire logic [31:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [31:0] rdata,
   // live debug buses from the link-layer core
   input wire logic [7:0] debug_bus_0,
   input wire logic [7:0] debug_bus_1,
   input wire logic [7:0] debug_bus_2,
   input wire logic [7:0] debug_bus_3,
   // accesses watched by the zone flags
   input wire logic reg_acc_valid,
   input wire logic [15:0] reg_acc_addr,
   input wire logic mem_acc_valid,
   input wire logic [15:0] mem_acc_addr,
   // event interrupt and its acknowledge
   input wire logic evt_irq,
   input wire logic evt_ack,
   // pointer checks
   input wire logic rx_buf_chk,
   input wire logic [15:0] rx_buf_ptr,
   input wire logic tx_buf_chk,
   input wire logic [15:0] tx_buf_ptr,
   input wire logic adv_event,
   input wire logic [7:0] tx_pkt_len,
   input wire logic rx_desc_chk,
   input wire logic [15:0] rx_desc_ptr,
   input wire logic tx_desc_chk,
   input wire logic [15:0] tx_desc_ptr,
   // control-structure format check
   input wire logic fmt_chk,
   input wire logic [`BDES_FMT_W-1:0] fmt_code,
   // channel map check at the start of hopping
   input wire logic hop_start,
   input wire logic [`BDES_CHMAP_W-1:0] chan_map,
   input wire logic [`BDES_CHCNT_W-1:0] good_count,
   // zone flags
   output logic regzone_hit,
   output logic memzone_hit
);

   bdes_top_s s;
   bdes_top_s next_s;
   bdes_err_if eif ();
   logic [31:0] dbg_word;
   logic [31:0] err_word;
   logic [31:0] zstat_word;
   logic [15:0] regzone_upper;
   logic [15:0] memzone_upper;
   logic [15:0] regzone_lower;
   logic [15:0] memzone_lower;
   logic [7:0] dbg_byte0_view;
   logic [7:0] dbg_byte1_view;
   logic [7:0] dbg_byte2_view;
   logic [7:0] dbg_byte3_view;
   logic regzone_hit_q;
   logic memzone_hit_q;

   function automatic logic [31:0] read_mux(
      input logic [31:0] a,
      input logic [31:0] dbg,
      input logic [31:0] upper,
      input logic [31:0] lower,
      input logic [31:0] err,
      input logic [31:0] zstat);
      logic [31:0] d;
      d = '0;
      case (a)
         `BDES_ADDR_DBG_MIRROR: begin
            d = dbg;
         end
         `BDES_ADDR_ZONE_UPPER: begin
            d = upper;
         end
         `BDES_ADDR_ZONE_LOWER: begin
            d = lower;
         end
         `BDES_ADDR_ERR_FLAGS: begin
            d = err;
         end
         `BDES_ADDR_ZONE_STAT: begin
            d = zstat;
         end
         // the clear word is a command and unmapped words read zero
         default: begin
            d = '0;
         end
      endcase
      return d;
   endfunction

   // debug bytes are taken as they stand, no snapshot: debug use only
   assign dbg_byte0_view = debug_bus_0;
   assign dbg_byte1_view = debug_bus_1;
   assign dbg_byte2_view = debug_bus_2;
   assign dbg_byte3_view = debug_bus_3;
   assign dbg_word = {dbg_byte3_view, dbg_byte2_view,
                      dbg_byte1_view, dbg_byte0_view}; // RL1

   assign regzone_upper =
      s.zone_upper[`BDES_REGZONE_MSB:`BDES_REGZONE_LSB]; // RL2
   assign memzone_upper =
      s.zone_upper[`BDES_MEMZONE_MSB:`BDES_MEMZONE_LSB]; // RL3
   assign regzone_lower =
      s.zone_lower[`BDES_REGZONE_MSB:`BDES_REGZONE_LSB]; // RL4
   assign memzone_lower =
      s.zone_lower[`BDES_MEMZONE_MSB:`BDES_MEMZONE_LSB]; // RL5

   always_comb begin
      err_word = '0;
      err_word[`BDES_ERR_MSB:`BDES_ERR_LSB] = eif.flags;
      zstat_word = '0;
      zstat_word[`BDES_ZSTAT_REG_BIT] = regzone_hit_q;
      zstat_word[`BDES_ZSTAT_MEM_BIT] = memzone_hit_q;
   end

   always_comb begin
      next_s = s;
      next_s.clr = '0;
      // read data stand for exactly the cycle after the strobe
      next_s.rdata = '0;
      if (rd) begin
         next_s.rdata = read_mux(addr, dbg_word, s.zone_upper,
                                 s.zone_lower, err_word, zstat_word);
      end
      // mirror, flags and zone status are read-only: writes drop silently
      if (wr) begin
         case (addr)
            `BDES_ADDR_ZONE_UPPER: begin
               next_s.zone_upper = wdata; // RL2 RL3
            end
            `BDES_ADDR_ZONE_LOWER: begin
               next_s.zone_lower = wdata; // RL4 RL5
            end
            `BDES_ADDR_ERR_CLEAR: begin
               next_s.clr = wdata[`BDES_ERR_MSB:`BDES_ERR_LSB];
            end
            default: begin
               next_s.clr = '0; // RL13
            end
         endcase
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         s.zone_upper <= `BDES_RST_LIMITS; // RL2
         s.zone_lower <= `BDES_RST_LIMITS;
         s.rdata <= `BDES_RST_WORD;
         s.clr <= '0;
      end else begin
         s <= next_s;
      end
   end

   // checks come from logic on this clock, so no synchroniser
   assign eif.evt_irq = evt_irq;
   assign eif.evt_ack = evt_ack;
   assign eif.rx_buf_chk = rx_buf_chk;
   assign eif.rx_buf_ptr = rx_buf_ptr;
   assign eif.tx_buf_chk = tx_buf_chk;
   assign eif.tx_buf_ptr = tx_buf_ptr;
   assign eif.adv_event = adv_event;
   assign eif.tx_pkt_len = tx_pkt_len;
   assign eif.rx_desc_chk = rx_desc_chk;
   assign eif.rx_desc_ptr = rx_desc_ptr;
   assign eif.tx_desc_chk = tx_desc_chk;
   assign eif.tx_desc_ptr = tx_desc_ptr;
   assign eif.fmt_chk = fmt_chk;
   assign eif.fmt_code = fmt_code;
   assign eif.hop_start = hop_start;
   assign eif.chan_map = chan_map;
   assign eif.good_count = good_count;
   // clear pulse is registered, so it lands one cycle after the write
   assign eif.clr = s.clr;

   bdes_err_flags u_err (
      .ref_clk (ref_clk),
      .rst_n (rst_n),
      .chk (eif.mon)
   );

   bdes_zone_cmp u_regzone (
      .ref_clk (ref_clk),
      .rst_n (rst_n),
      .acc_valid (reg_acc_valid),
      .acc_addr (reg_acc_addr),
      .lower (regzone_lower),
      .upper (regzone_upper),
      .hit (regzone_hit_q)
   );

   bdes_zone_cmp u_memzone (
      .ref_clk (ref_clk),
      .rst_n (rst_n),
      .acc_valid (mem_acc_valid),
      .acc_addr (mem_acc_addr),
      .lower (memzone_lower),
      .upper (memzone_upper),
      .hit (memzone_hit_q)
   );

   assign rdata = s.rdata;
   assign regzone_hit = regzone_hit_q;
   assign memzone_hit = memzone_hit_q;

endmodule : bdes_top

// ===== testbench/bdes_top_asserts.sv
`include "bdes_defines.svh"

module bdes_top_asserts
   import bdes_pkg::*;
(
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst_n,
   // register port
   input wire logic [31:0] addr,
   input wire logic [31:0] wdata,
   input wire logic wr,
   input wire logic rd,
   input wire logic [31:0] rdata,
   // debug buses
   input wire logic [7:0] debug_bus_0,
   input wire logic [7:0] debug_bus_1,
   input wire logic [7:0] debug_bus_2,
   input wire logic [7:0] debug_bus_3,
   // zone watch
   input wire logic reg_acc_valid,
   input wire logic [15:0] reg_acc_addr,
   input wire logic mem_acc_valid,
   input wire logic [15:0] mem_acc_addr,
   input wire logic regzone_hit,
   input wire logic memzone_hit,
   // error sources
   input wire logic evt_irq,
   input wire logic evt_ack,
   input wire logic rx_buf_chk,
   input wire logic [15:0] rx_buf_ptr,
   input wire logic hop_start,
   input wire logic [`BDES_CHMAP_W-1:0] chan_map,
   input wire logic [`BDES_CHCNT_W-1:0] good_count
);
   // shadow limits move on the write edge, so hit timing matches the block
   logic [31:0] up_q;
   logic [31:0] lo_q;

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         up_q <= 32'h0;
         lo_q <= 32'h0;
      end else if (wr) begin
         if (addr == `BDES_ADDR_ZONE_UPPER) up_q <= wdata;
         if (addr == `BDES_ADDR_ZONE_LOWER) lo_q <= wdata;
      end
   end

   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!rst_n);

   mirror_read_a: assert property (rd && addr == `BDES_ADDR_DBG_MIRROR
      |=> rdata == {$past(debug_bus_3), $past(debug_bus_2),
      $past(debug_bus_1), $past(debug_bus_0)}) else $error("mirror bad");
   rdata_idle_a: assert property (!rd |=> rdata == 32'h0)
      else $error("rdata not idle");
   upper_rw_a: assert property (rd && addr == `BDES_ADDR_ZONE_UPPER
      |=> rdata == $past(up_q))
      else $error("upper limit lost");
   lower_rw_a: assert property (rd && addr == `BDES_ADDR_ZONE_LOWER
      |=> rdata == $past(lo_q))
      else $error("lower limit lost");
   mem_hit_a: assert property (1'b1 |=> memzone_hit == $past(
      mem_acc_valid && lo_q[15:0] <= mem_acc_addr
      && mem_acc_addr <= up_q[15:0])) else $error("mem hit bad");
   reg_hit_a: assert property (1'b1 |=> regzone_hit == $past(
      reg_acc_valid && lo_q[31:16] <= reg_acc_addr
      && reg_acc_addr <= up_q[31:16])) else $error("reg hit bad");
   rx_null_a: assert property (rx_buf_chk && rx_buf_ptr == 16'h0
      ##2 rd && addr == `BDES_ADDR_ERR_FLAGS |=> rdata[16])
      else $error("rx null missed");
   chan_count_a: assert property (hop_start
      && $countones(chan_map) != good_count
      ##2 rd && addr == `BDES_ADDR_ERR_FLAGS |=> rdata[11])
      else $error("chan map missed");
   irq_overlap_a: assert property (evt_irq ##1 evt_irq && !evt_ack
      ##2 rd && addr == `BDES_ADDR_ERR_FLAGS |=> rdata[17])
      else $error("overlap missed");
endmodule // bdes_top_asserts

bind bdes_top bdes_top_asserts u_bdes_top_asserts (.ref_clk, .rst_n,
   .addr, .wdata, .wr, .rd, .rdata, .debug_bus_0, .debug_bus_1,
   .debug_bus_2, .debug_bus_3, .reg_acc_valid, .reg_acc_addr,
   .mem_acc_valid, .mem_acc_addr, .regzone_hit, .memzone_hit, .evt_irq,
   .evt_ack, .rx_buf_chk, .rx_buf_ptr, .hop_start, .chan_map, .good_count);

// ===== testbench/bdes_top_test.sv
`include "bdes_defines.svh"

module bdes_top_test
   import bdes_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;

   logic ref_clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0;
   logic [31:0] addr = 32'h0, wdata = 32'h0, rdata;
   logic [7:0] debug_bus_0 = 8'h0, debug_bus_1 = 8'h0, tx_pkt_len = 8'h0;
   logic [7:0] debug_bus_2 = 8'h0, debug_bus_3 = 8'h0;
   logic [15:0] reg_acc_addr = 16'h0, mem_acc_addr = 16'h0;
   logic [15:0] rx_buf_ptr = 16'h0, tx_buf_ptr = 16'h0;
   logic [15:0] rx_desc_ptr = 16'h0, tx_desc_ptr = 16'h0;
   logic reg_acc_valid = 1'b0, mem_acc_valid = 1'b0, adv_event = 1'b0;
   logic evt_irq = 1'b0, evt_ack = 1'b0, rx_buf_chk = 1'b0;
   logic tx_buf_chk = 1'b0, rx_desc_chk = 1'b0, tx_desc_chk = 1'b0;
   logic fmt_chk = 1'b0, hop_start = 1'b0, regzone_hit, memzone_hit;
   logic [`BDES_FMT_W-1:0] fmt_code = 5'h0;
   // five channels in use, one of them at the top end of the map
   logic [`BDES_CHMAP_W-1:0] chan_map = 37'h10_0000_000f;
   logic [`BDES_CHCNT_W-1:0] good_count = 6'h0;
   int bad_count = 0, total_checks = 0;

   bdes_top u_bdes_top (.ref_clk, .rst_n, .addr, .wdata, .wr, .rd, .rdata,
      .debug_bus_0, .debug_bus_1, .debug_bus_2, .debug_bus_3,
      .reg_acc_valid, .reg_acc_addr, .mem_acc_valid, .mem_acc_addr,
      .evt_irq, .evt_ack, .rx_buf_chk, .rx_buf_ptr, .tx_buf_chk,
      .tx_buf_ptr, .adv_event, .tx_pkt_len, .rx_desc_chk, .rx_desc_ptr,
      .tx_desc_chk, .tx_desc_ptr, .fmt_chk, .fmt_code, .hop_start,
      .chan_map, .good_count, .regzone_hit, .memzone_hit);

   initial begin
      forever #10 ref_clk = ~ref_clk;
   end

   task summarize();
      $display("mismatches %0d of %0d checks", bad_count, total_checks);
      if (bad_count == 0 && total_checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask

   task chk(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task wr_reg(input logic [31:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge ref_clk);
      wr <= 1'b0;
   endtask

   // data stands only one cycle, so sample it mid-cycle right after
   task rd_chk(input logic [31:0] a, input logic [31:0] e);
      @(posedge ref_clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge ref_clk);
      rd <= 1'b0;
      @(negedge ref_clk);
      chk(rdata, e);
   endtask

   task zone(input logic [15:0] ra, input logic [15:0] ma,
             input logic re, input logic me);
      @(posedge ref_clk);
      reg_acc_valid <= 1'b1;
      reg_acc_addr <= ra;
      mem_acc_valid <= 1'b1;
      mem_acc_addr <= ma;
      @(posedge ref_clk);
      reg_acc_valid <= 1'b0;
      mem_acc_valid <= 1'b0;
      @(negedge ref_clk);
      chk(regzone_hit, re);
      chk(memzone_hit, me);
   endtask

   task err(input int k, input logic [15:0] p, input logic a,
            input logic [7:0] n, input logic [31:0] e);
      @(posedge ref_clk);
      {rx_buf_ptr, tx_buf_ptr, rx_desc_ptr, tx_desc_ptr} <= {4{p}};
      adv_event <= a;
      tx_pkt_len <= n;
      fmt_code <= p[4:0];
      good_count <= p[5:0];
      {hop_start, fmt_chk, tx_desc_chk, rx_desc_chk, tx_buf_chk,
         rx_buf_chk} <= 6'h1 << k;
      @(posedge ref_clk);
      {hop_start, fmt_chk, tx_desc_chk, rx_desc_chk, tx_buf_chk,
         rx_buf_chk} <= 6'h0;
      rd_chk(`BDES_ADDR_ERR_FLAGS, e);
      wr_reg(`BDES_ADDR_ERR_CLEAR, 32'h0003_f800);
      rd_chk(`BDES_ADDR_ERR_FLAGS, 32'h0);
   endtask

   task evt(input logic i, input logic a);
      @(posedge ref_clk);
      evt_irq <= i;
      evt_ack <= a;
   endtask

   initial begin
      repeat (6) @(posedge ref_clk);
      rst_n <= 1'b1;
      // every word, clear and zone status included, reads zero after reset
      for (int i = 0; i < 6; i++) begin
         rd_chk(`BDES_ADDR_DBG_MIRROR + 32'(4 * i), 32'h0);
      end
      @(posedge ref_clk);
      debug_bus_0 <= 8'h01;
      debug_bus_1 <= 8'h23;
      debug_bus_2 <= 8'h45;
      debug_bus_3 <= 8'h67;
      rd_chk(`BDES_ADDR_DBG_MIRROR, 32'h6745_2301);
      wr_reg(`BDES_ADDR_DBG_MIRROR, 32'hffff_ffff);
      rd_chk(`BDES_ADDR_DBG_MIRROR, 32'h6745_2301);
      wr_reg(`BDES_ADDR_ZONE_UPPER, 32'h0120_0080);
      rd_chk(`BDES_ADDR_ZONE_UPPER, 32'h0120_0080);
      wr_reg(`BDES_ADDR_ZONE_LOWER, 32'h0100_0040);
      rd_chk(`BDES_ADDR_ZONE_LOWER, 32'h0100_0040);
      wr_reg(`BDES_ADDR_ERR_FLAGS, 32'hffff_ffff);
      rd_chk(`BDES_ADDR_ERR_FLAGS, 32'h0);
      rd_chk(32'h4000_0070, 32'h0);
      zone(16'h0100, 16'h003f, 1'b1, 1'b0);
      zone(16'h0120, 16'h0040, 1'b1, 1'b1);
      zone(16'h0121, 16'h0080, 1'b0, 1'b1);
      zone(16'h00ff, 16'h0081, 1'b0, 1'b0);
      // hold both accesses inside their zones across a status read
      @(posedge ref_clk);
      reg_acc_addr <= 16'h0110;
      mem_acc_addr <= 16'h0060;
      {reg_acc_valid, mem_acc_valid} <= 2'b11;
      rd_chk(`BDES_ADDR_ZONE_STAT, 32'h0000_0003);
      @(posedge ref_clk);
      {reg_acc_valid, mem_acc_valid} <= 2'b00;
      err(0, 16'h0, 1'b0, 8'h0, 32'h0001_0000);
      err(0, 16'h1, 1'b0, 8'h0, 32'h0);
      err(1, 16'h0, 1'b1, 8'h0, 32'h0000_8000);
      err(1, 16'h0, 1'b0, 8'h0, 32'h0);
      err(1, 16'h0, 1'b0, 8'h1, 32'h0000_8000);
      err(2, 16'h0, 1'b0, 8'h0, 32'h0000_4000);
      err(3, 16'h0, 1'b1, 8'h0, 32'h0000_2000);
      err(3, 16'h0, 1'b0, 8'h0, 32'h0);
      err(4, 16'hf, 1'b0, 8'h0, 32'h0);
      err(4, 16'h10, 1'b0, 8'h0, 32'h0000_1000);
      err(5, 16'h5, 1'b0, 8'h0, 32'h0);
      err(5, 16'h6, 1'b0, 8'h0, 32'h0000_0800);
      evt(1'b1, 1'b0);
      evt(1'b1, 1'b1);
      evt(1'b0, 1'b1);
      evt(1'b0, 1'b0);
      rd_chk(`BDES_ADDR_ERR_FLAGS, 32'h0);
      evt(1'b1, 1'b0);
      evt(1'b1, 1'b0);
      evt(1'b0, 1'b0);
      rd_chk(`BDES_ADDR_ERR_FLAGS, 32'h0002_0000);
      summarize();
   end

   initial begin
      #(20 * 5000);
      bad_count++;
      summarize();
   end
endmodule // bdes_top_test
